// file: mcuic_params.svh
// offsets, field positions, reset values and vectors of the interrupt block
`ifndef MCUIC_PARAMS_SVH
`define MCUIC_PARAMS_SVH
`define MCUIC_IDX_CPU_STATUS 8'h06
`define MCUIC_IDX_INT_STATUS 8'h07
`define MCUIC_IDX_PERIPH_REQ 8'h16
`define MCUIC_IDX_PERIPH_EN 8'h17
`define MCUIC_IDX_SW_STATUS 8'h20
`define MCUIC_IDX_SW_MASK 8'h21
`define MCUIC_ADDR_W 10
`define MCUIC_CPU_GLINT_BIT 4
`define MCUIC_CPU_RESET 8'h10
`define MCUIC_INT_RESET 8'h00
`define MCUIC_PIR_RESET 8'h02
`define MCUIC_PIE_RESET 8'h00
`define MCUIC_INT_PEF 7
`define MCUIC_INT_CKF 6
`define MCUIC_INT_T0F 5
`define MCUIC_INT_EXF 4
`define MCUIC_INT_PEE 3
`define MCUIC_INT_CKE 2
`define MCUIC_INT_T0E 1
`define MCUIC_INT_EXE 0
`define MCUIC_VEC_RESET 16'h0000
`define MCUIC_VEC_EXT 16'h0008
`define MCUIC_VEC_T0 16'h0010
`define MCUIC_VEC_CK 16'h0018
`define MCUIC_VEC_PERIPH 16'h0020
`define MCUIC_SW_VECTOR 0
`define MCUIC_SW_RETURN 1
`define MCUIC_SW_BADCLR 2
`define MCUIC_SW_W 3
`endif

// file: mcuic_pkg.sv
// types of the interrupt block
package mcuic_pkg;
    typedef enum logic [1:0] {
        MCUIC_SEL_EXT,
        MCUIC_SEL_T0,
        MCUIC_SEL_CK,
        MCUIC_SEL_PER
    } mcuic_sel_type;
endpackage : mcuic_pkg

// file: mcuic_top.sv
// interrupt controller with core hand-off and ahb-lite registers
//
// Added by the designer: the AHB-Lite interface to the registers.
`include "mcuic_params.svh"
`timescale 1ns/10ps
`default_nettype none
module mcuic_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic EXT_IRQ_PIN,
    input wire logic CLK_PIN_EDGE,
    input wire logic TIMER_ZERO_OVF,
    input wire logic [7:0] PERIPH_EVENTS,
    input wire logic CORE_ACK,
    input wire logic CORE_TWO_CYCLE,
    input wire logic CORE_RETURN,
    input wire logic CORE_SLEEPING,
    input wire logic [15:0] RETURN_ADDR,
    output logic VECTOR_REQ,
    output logic [15:0] VECTOR_ADDR,
    output logic STACK_PUSH,
    output logic [15:0] STACK_PUSH_ADDR,
    output logic STACK_POP,
    output logic WAKE_UP,
    output logic GLOBAL_IRQ_DISABLE,
    output logic IRQ,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic [7:0] cpu_q, ints_q, pir_q, pie_q;
    logic [`MCUIC_SW_W-1:0] sws_q, swm_q;
    logic wr_ph_q;
    logic [7:0] widx_q;
    logic [7:0] ridx;
    logic ext_rise, ext_wait_q;
    logic periph_pend, glint, pend_any, bad_clear;
    logic [3:0] enab_clr, flag_set;
    logic wr_int, wr_pir, wr_pie, wr_cpu, wr_sws, wr_swm;
    logic take;
    logic [15:0] vec_d;
    mcuic_pkg::mcuic_sel_type sel;

    // pin sync, rising edge detect from stage two onward
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= EXT_IRQ_PIN;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    assign ext_rise = ext_s2_q & ~ext_s3_q;

    // ahb-lite decode, word index from byte address
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign ridx = HADDR[`MCUIC_ADDR_W-1:2];

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wr_ph_q <= 1'b0;
            widx_q <= 8'h00;
        end
        else if (HREADY)
        begin
            wr_ph_q <= HSEL & HTRANS[1] & HWRITE;
            widx_q <= ridx;
        end
    end
    assign wr_cpu = wr_ph_q && widx_q == `MCUIC_IDX_CPU_STATUS;
    assign wr_int = wr_ph_q && widx_q == `MCUIC_IDX_INT_STATUS;
    assign wr_pir = wr_ph_q && widx_q == `MCUIC_IDX_PERIPH_REQ;
    assign wr_pie = wr_ph_q && widx_q == `MCUIC_IDX_PERIPH_EN;
    assign wr_sws = wr_ph_q && widx_q == `MCUIC_IDX_SW_STATUS;
    assign wr_swm = wr_ph_q && widx_q == `MCUIC_IDX_SW_MASK;

    assign periph_pend = |(pir_q & pie_q);
    assign glint = cpu_q[`MCUIC_CPU_GLINT_BIT];

    // hold pin request one cycle during two-cycle instruction
    always_ff @(posedge CLK)
    begin
        if (RST)
            ext_wait_q <= 1'b0;
        else
            ext_wait_q <= ext_rise & CORE_TWO_CYCLE;
    end

    // flag events per source: ext, t0, clock pin
    assign flag_set = {1'b0, CLK_PIN_EDGE, TIMER_ZERO_OVF, ext_rise};
    // enables dropping by software in this cycle
    assign enab_clr = {~HWDATA[`MCUIC_INT_PEE] & ints_q[`MCUIC_INT_PEE],
                       ~HWDATA[`MCUIC_INT_CKE] & ints_q[`MCUIC_INT_CKE],
                       ~HWDATA[`MCUIC_INT_T0E] & ints_q[`MCUIC_INT_T0E],
                       ~HWDATA[`MCUIC_INT_EXE] & ints_q[`MCUIC_INT_EXE]}
                      & {4{wr_int}};
    // flag set as its enable clears with interrupts on
    assign bad_clear = ~glint & |(enab_clr
        & (flag_set | {|PERIPH_EVENTS, 3'b000}));

    // gated request per source, global disable blocks
    assign pend_any = ~glint & (bad_clear
        | (ints_q[`MCUIC_INT_EXF] & ints_q[`MCUIC_INT_EXE] & ~ext_wait_q)
        | (ints_q[`MCUIC_INT_T0F] & ints_q[`MCUIC_INT_T0E])
        | (ints_q[`MCUIC_INT_CKF] & ints_q[`MCUIC_INT_CKE])
        | (periph_pend & ints_q[`MCUIC_INT_PEE]));

    // fixed priority choice of four vectors
    always_comb
    begin
        if (ints_q[`MCUIC_INT_EXF] & ints_q[`MCUIC_INT_EXE] & ~ext_wait_q)
            sel = mcuic_pkg::MCUIC_SEL_EXT;
        else if (ints_q[`MCUIC_INT_T0F] & ints_q[`MCUIC_INT_T0E])
            sel = mcuic_pkg::MCUIC_SEL_T0;
        else if (ints_q[`MCUIC_INT_CKF] & ints_q[`MCUIC_INT_CKE])
            sel = mcuic_pkg::MCUIC_SEL_CK;
        else
            sel = mcuic_pkg::MCUIC_SEL_PER;
    end

    // vector address table, reset address on bad clear
    always_comb
    begin
        unique case (sel)
            mcuic_pkg::MCUIC_SEL_EXT: vec_d = `MCUIC_VEC_EXT;
            mcuic_pkg::MCUIC_SEL_T0: vec_d = `MCUIC_VEC_T0;
            mcuic_pkg::MCUIC_SEL_CK: vec_d = `MCUIC_VEC_CK;
            mcuic_pkg::MCUIC_SEL_PER: vec_d = `MCUIC_VEC_PERIPH;
        endcase
        if (bad_clear)
            vec_d = `MCUIC_VEC_RESET;
    end

    // wake-up on any event even with global disable set, vectors only with it clear
    assign WAKE_UP = CORE_SLEEPING & |(flag_set | {3'b000, |PERIPH_EVENTS});
    assign take = VECTOR_REQ & CORE_ACK;

    // request to core, held until acknowledged
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            VECTOR_REQ <= 1'b0;
            VECTOR_ADDR <= `MCUIC_VEC_RESET;
        end
        else if (take)
            VECTOR_REQ <= 1'b0;
        else if (!VECTOR_REQ && pend_any)
        begin
            VECTOR_REQ <= 1'b1;
            VECTOR_ADDR <= vec_d;
        end
    end

    // push return address and pop on return
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            STACK_PUSH <= 1'b0;
            STACK_PUSH_ADDR <= 16'h0000;
            STACK_POP <= 1'b0;
        end
        else
        begin
            STACK_PUSH <= take;
            STACK_POP <= CORE_RETURN;
            if (take)
                STACK_PUSH_ADDR <= RETURN_ADDR;
        end
    end

    // set global disable on response, clear on return
    always_ff @(posedge CLK)
    begin
        if (RST)
            cpu_q <= `MCUIC_CPU_RESET;
        else if (take)
            cpu_q[`MCUIC_CPU_GLINT_BIT] <= 1'b1;
        else if (CORE_RETURN)
            cpu_q[`MCUIC_CPU_GLINT_BIT] <= 1'b0;
        else if (wr_cpu)
            cpu_q[`MCUIC_CPU_GLINT_BIT] <= HWDATA[`MCUIC_CPU_GLINT_BIT];
    end
    assign GLOBAL_IRQ_DISABLE = glint;

    // flags, enables of interrupt status register
    always_ff @(posedge CLK)
    begin
        if (RST)
            ints_q <= `MCUIC_INT_RESET;
        else
        begin
            if (wr_int)
                ints_q[6:0] <= HWDATA[6:0];
            // hardware clear of own-vector flag on take
            if (take && VECTOR_ADDR == `MCUIC_VEC_EXT)
                ints_q[`MCUIC_INT_EXF] <= 1'b0;
            if (take && VECTOR_ADDR == `MCUIC_VEC_T0)
                ints_q[`MCUIC_INT_T0F] <= 1'b0;
            if (take && VECTOR_ADDR == `MCUIC_VEC_CK)
                ints_q[`MCUIC_INT_CKF] <= 1'b0;
            // events set flags regardless, set wins over clear
            if (flag_set[0])
                ints_q[`MCUIC_INT_EXF] <= 1'b1;
            if (flag_set[1])
                ints_q[`MCUIC_INT_T0F] <= 1'b1;
            if (flag_set[2])
                ints_q[`MCUIC_INT_CKF] <= 1'b1;
            ints_q[`MCUIC_INT_PEF] <= 1'b0;
        end
    end

    // peripheral flags cleared by software only, event wins
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pir_q <= `MCUIC_PIR_RESET;
            pie_q <= `MCUIC_PIE_RESET;
        end
        else
        begin
            pir_q <= (wr_pir ? HWDATA[7:0] : pir_q) | PERIPH_EVENTS;
            if (wr_pie)
                pie_q <= HWDATA[7:0];
        end
    end

    // sticky block events, write one clears, mask gates irq
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sws_q <= '0;
            swm_q <= '0;
        end
        else
        begin
            sws_q <= (sws_q & ~(wr_sws ? HWDATA[`MCUIC_SW_W-1:0] : '0))
                     | {bad_clear, CORE_RETURN, take};
            if (wr_swm)
                swm_q <= HWDATA[`MCUIC_SW_W-1:0];
        end
    end
    assign IRQ = |(sws_q & swm_q);

    always_ff @(posedge CLK)
    begin
        if (RST)
            HRDATA <= 32'h00000000;
        else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
        begin
            unique case (ridx)
                `MCUIC_IDX_CPU_STATUS: HRDATA <= {24'h000000, cpu_q};
                `MCUIC_IDX_INT_STATUS:
                    HRDATA <= {24'h000000, periph_pend, ints_q[6:0]};
                `MCUIC_IDX_PERIPH_REQ: HRDATA <= {24'h000000, pir_q};
                `MCUIC_IDX_PERIPH_EN: HRDATA <= {24'h000000, pie_q};
                `MCUIC_IDX_SW_STATUS: HRDATA <= {29'h0000000, sws_q};
                `MCUIC_IDX_SW_MASK: HRDATA <= {29'h0000000, swm_q};
                default: HRDATA <= 32'h00000000;
            endcase
        end
    end

    // global disable blocks new requests
    no_vec_masked_a: assert property (@(posedge CLK) disable iff (RST)
        (glint && !VECTOR_REQ) |=> !VECTOR_REQ)
        else $error("vector raised while disabled");
    // response sets disable and pushes
    take_sets_dis_a: assert property (@(posedge CLK) disable iff (RST)
        take |=> (glint && STACK_PUSH && STACK_PUSH_ADDR == $past(RETURN_ADDR)))
        else $error("response did not disable or push");
    // return clears disable and pops
    ret_clears_a: assert property (@(posedge CLK) disable iff (RST)
        (CORE_RETURN && !take) |=> (!glint && STACK_POP))
        else $error("return did not clear disable");
    // timer zero event sets its flag
    flag_sets_a: assert property (@(posedge CLK) disable iff (RST)
        TIMER_ZERO_OVF |=> ints_q[`MCUIC_INT_T0F])
        else $error("timer flag not set");
    // pending flag as read back equals gated or
    pend_or_a: assert property (@(posedge CLK) disable iff (RST)
        (HREADY && HSEL && HTRANS[1] && !HWRITE
         && ridx == `MCUIC_IDX_INT_STATUS)
        |=> HRDATA[`MCUIC_INT_PEF] == |($past(pir_q) & $past(pie_q)))
        else $error("pending flag wrong");
    // timer zero take clears its flag
    own_clear_a: assert property (@(posedge CLK) disable iff (RST)
        (take && VECTOR_ADDR == `MCUIC_VEC_T0 && !TIMER_ZERO_OVF
         && !wr_int) |=> !ints_q[`MCUIC_INT_T0F])
        else $error("timer flag kept after vector");
    // peripheral flags survive vectoring
    per_keep_a: assert property (@(posedge CLK) disable iff (RST)
        (take && !wr_pir) |=> (pir_q == ($past(pir_q) | $past(PERIPH_EVENTS))))
        else $error("peripheral flags changed");
    // request holds until ack
    req_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (VECTOR_REQ && !CORE_ACK) |=> (VECTOR_REQ && $stable(VECTOR_ADDR)))
        else $error("request dropped early");
    // bad clear goes to reset address
    bad_reset_a: assert property (@(posedge CLK) disable iff (RST)
        (bad_clear && !VECTOR_REQ) |=> VECTOR_ADDR == `MCUIC_VEC_RESET)
        else $error("bad clear not to reset");
    vec_ext_c: cover property (@(posedge CLK) take
        && VECTOR_ADDR == `MCUIC_VEC_EXT);
    vec_per_c: cover property (@(posedge CLK) take
        && VECTOR_ADDR == `MCUIC_VEC_PERIPH);
    ret_c: cover property (@(posedge CLK) STACK_POP);
    irq_c: cover property (@(posedge CLK) IRQ);
endmodule : mcuic_top
`default_nettype wire

// file: mcuic_core_model.sv
// core sequencer model: takes vectors, keeps the return stack
`timescale 1ns/10ps
`default_nettype none
module mcuic_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic vector_req,
    input wire logic [15:0] vector_addr,
    input wire logic stack_push,
    input wire logic [15:0] stack_push_addr,
    input wire logic stack_pop,
    input wire logic [3:0] ack_wait,
    output logic core_ack,
    output logic [15:0] return_addr,
    output logic [15:0] last_vec,
    output logic [15:0] ret_at_take,
    output logic [15:0] stack_top
);
    logic [3:0] wait_q;
    logic [15:0] stack_q [0:15];
    logic [3:0] sp_q;
    assign stack_top = stack_q[sp_q - 4'h1];
    // ack after a chosen wait; vector taken while req and ack
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core_ack <= 1'b0;
            wait_q <= 4'h0;
            last_vec <= 16'hffff;
            ret_at_take <= 16'h0000;
        end
        else if (vector_req && core_ack)
        begin
            core_ack <= 1'b0;
            wait_q <= 4'h0;
            last_vec <= vector_addr;
            ret_at_take <= return_addr;
        end
        else if (vector_req)
        begin
            wait_q <= wait_q + 4'h1;
            core_ack <= (wait_q >= ack_wait);
        end
    end
    // program counter runs so every pushed address differs
    always_ff @(posedge clk)
    begin
        if (rst)
            return_addr <= 16'h0100;
        else
            return_addr <= return_addr + 16'h0001;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            sp_q <= 4'h0;
        else if (stack_push)
        begin
            stack_q[sp_q] <= stack_push_addr;
            sp_q <= sp_q + 4'h1;
        end
        else if (stack_pop)
            sp_q <= sp_q - 4'h1;
    end
endmodule : mcuic_core_model
`default_nettype wire

// file: mcuic_top_tb_top.sv
// self-checking bench of the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module mcuic_top_tb_top;
    logic CLK = 0, RST = 1, EXT_IRQ_PIN = 0, CLK_PIN_EDGE = 0;
    logic TIMER_ZERO_OVF = 0, CORE_TWO_CYCLE = 0, CORE_RETURN = 0;
    logic CORE_SLEEPING = 0, CORE_ACK, HSEL = 0, HWRITE = 0;
    logic [7:0] PERIPH_EVENTS = 8'h00;
    logic [15:0] RETURN_ADDR, VECTOR_ADDR, STACK_PUSH_ADDR, last_vec, ret_tk;
    logic [15:0] stk_top;
    logic VECTOR_REQ, STACK_PUSH, STACK_POP, WAKE_UP, GLOBAL_IRQ_DISABLE;
    logic IRQ, HREADYOUT, HRESP;
    logic [1:0] HTRANS = 2'b00;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd_q;
    int error_cnt = 0, num_checks = 0, n0, n1;
    typedef struct {logic [7:0] en, peripheral_enable_mask; int ev; logic [15:0] vec;
        logic [7:0] aft;} mcuic_row_type;
    mcuic_row_type rows[4] = '{'{8'h01, 8'h00, 0, 16'h0008, 8'h01},
        '{8'h02, 8'h00, 1, 16'h0010, 8'h02},
        '{8'h04, 8'h00, 2, 16'h0018, 8'h04},
        '{8'h08, 8'h10, 3, 16'h0020, 8'h88}};
    logic [31:0] ra[7] = '{32'h18, 32'h1c, 32'h58, 32'h5c, 32'h80, 32'h84,
        32'h40};
    logic [7:0] rv[7] = '{8'h10, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    always #4 CLK = ~CLK;
    mcuic_top dut_u (.CLK(CLK), .RST(RST), .EXT_IRQ_PIN(EXT_IRQ_PIN),
        .CLK_PIN_EDGE(CLK_PIN_EDGE), .TIMER_ZERO_OVF(TIMER_ZERO_OVF),
        .PERIPH_EVENTS(PERIPH_EVENTS), .CORE_ACK(CORE_ACK),
        .CORE_TWO_CYCLE(CORE_TWO_CYCLE), .CORE_RETURN(CORE_RETURN),
        .CORE_SLEEPING(CORE_SLEEPING), .RETURN_ADDR(RETURN_ADDR),
        .VECTOR_REQ(VECTOR_REQ), .VECTOR_ADDR(VECTOR_ADDR),
        .STACK_PUSH(STACK_PUSH), .STACK_PUSH_ADDR(STACK_PUSH_ADDR),
        .STACK_POP(STACK_POP), .WAKE_UP(WAKE_UP),
        .GLOBAL_IRQ_DISABLE(GLOBAL_IRQ_DISABLE), .IRQ(IRQ), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010),
        .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP));
    mcuic_core_model core_u (.clk(CLK), .rst(RST), .vector_req(VECTOR_REQ),
        .vector_addr(VECTOR_ADDR), .stack_push(STACK_PUSH),
        .stack_push_addr(STACK_PUSH_ADDR), .stack_pop(STACK_POP),
        .ack_wait(4'h2), .core_ack(CORE_ACK), .return_addr(RETURN_ADDR),
        .last_vec(last_vec), .ret_at_take(ret_tk), .stack_top(stk_top));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one ahb-lite single transfer; f pulses timer zero in the data phase
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d, input logic f);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= a;
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= d;
        TIMER_ZERO_OVF <= f;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd_q = HRDATA;
        TIMER_ZERO_OVF <= 1'b0;
    endtask : xfer
    // fire one event: 0 pin, 1 timer zero, 2 clock pin, 3 peripheral
    task automatic fire(input int ev);
        @(posedge CLK);
        EXT_IRQ_PIN <= (ev == 0);
        TIMER_ZERO_OVF <= (ev == 1);
        CLK_PIN_EDGE <= (ev == 2);
        PERIPH_EVENTS <= (ev == 3) ? 8'h10 : 8'h00;
        @(posedge CLK);
        TIMER_ZERO_OVF <= 1'b0;
        CLK_PIN_EDGE <= 1'b0;
        PERIPH_EVENTS <= 8'h00;
    endtask : fire
    // wait for the push, then check disable and stack
    task automatic take(input logic [15:0] vec);
        int n;
        n = 0;
        do begin @(posedge CLK); n++; end while (STACK_PUSH !== 1'b1 && n < 60);
        chk(n < 60, 1'b1);
        chk(GLOBAL_IRQ_DISABLE, 1'b1);
        EXT_IRQ_PIN <= 1'b0;
        @(negedge CLK);
        chk(last_vec, vec);
        chk(stk_top, ret_tk);
    endtask : take
    // clear enables, then return from service
    task automatic ret;
        xfer(1, 32'h1c, 32'h0, 0);
        @(posedge CLK);
        CORE_RETURN <= 1'b1;
        @(posedge CLK);
        CORE_RETURN <= 1'b0;
        @(posedge CLK);
        chk(STACK_POP, 1'b1);
        chk(GLOBAL_IRQ_DISABLE, 1'b0);
    endtask : ret
    // pin-to-request latency with or without a two-cycle instruction
    task automatic lat(input logic two, output int n);
        xfer(1, 32'h1c, 32'h01, 0);
        CORE_TWO_CYCLE <= two;
        EXT_IRQ_PIN <= 1'b1;
        n = 0;
        do begin @(posedge CLK); n++; end while (VECTOR_REQ !== 1'b1 && n < 40);
        take(16'h0008);
        CORE_TWO_CYCLE <= 1'b0;
        ret;
    endtask : lat
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // watchdog against a hang
    initial
    begin
        #160000;
        error_cnt++;
        report_and_stop;
    end
    initial
    begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        // reset values, unmapped address reads zero
        foreach (ra[i])
        begin
            xfer(0, ra[i], 32'h0, 0);
            chk(rd_q[7:0], rv[i]);
            chk(HRESP, 1'b0);
        end
        foreach (rows[i])
        begin
            xfer(1, 32'h1c, {24'h0, rows[i].en}, 0);
            xfer(1, 32'h5c, {24'h0, rows[i].peripheral_enable_mask}, 0);
            xfer(1, 32'h18, 32'h0, 0);
            fire(rows[i].ev);
            take(rows[i].vec);
            xfer(0, 32'h1c, 32'h0, 0);
            chk(rd_q[7:0], rows[i].aft);
            ret;
        end
        // disabled core sleeping: flag sets, wake, no vector
        xfer(1, 32'h18, 32'h10, 0);
        xfer(1, 32'h1c, 32'h02, 0);
        CORE_SLEEPING <= 1'b1;
        @(posedge CLK);
        TIMER_ZERO_OVF <= 1'b1;
        @(negedge CLK);
        chk(WAKE_UP, 1'b1);
        @(posedge CLK);
        TIMER_ZERO_OVF <= 1'b0;
        CORE_SLEEPING <= 1'b0;
        repeat (10) @(posedge CLK);
        chk(VECTOR_REQ, 1'b0);
        xfer(0, 32'h1c, 32'h0, 0);
        chk(rd_q[7:0], 8'ha2);
        xfer(1, 32'h1c, 32'h0, 0);
        // enable cleared as its flag sets with interrupts on
        xfer(1, 32'h1c, 32'h02, 0);
        xfer(1, 32'h18, 32'h0, 0);
        xfer(1, 32'h1c, 32'h0, 1);
        take(16'h0000);
        ret;
        lat(0, n0);
        lat(1, n1);
        chk(n1, n0 + 1);
        // sticky status, mask, level interrupt, write-one clear
        chk(IRQ, 1'b0);
        xfer(1, 32'h84, 32'h01, 0);
        @(negedge CLK);
        chk(IRQ, 1'b1);
        xfer(0, 32'h80, 32'h0, 0);
        chk(rd_q[7:0], 8'h07);
        xfer(1, 32'h80, 32'h07, 0);
        xfer(0, 32'h80, 32'h0, 0);
        chk(rd_q[7:0], 8'h00);
        chk(IRQ, 1'b0);
        report_and_stop;
    end
endmodule : mcuic_top_tb_top
`default_nettype wire
